// *** btse_pkg.sv ***
`timescale 1ns/1ps
// Purpose: Shared constants and the bit-test leaf for the bit-test-and-skip execute slice.
// Assumes: 12-bit instruction words, 8-bit file registers, one core clock.
// Notes: The leaf module is purely combinational; the top registers everything it drives out.

// ============================================================
// Package
// ============================================================
package btse_pkg;
	localparam int INSTR_W = 12;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int BSEL_W = 3;
	localparam int OPC_W = 4;
	// Field positions inside the instruction word.
	localparam int FADDR_LSB = 0;
	localparam int BSEL_LSB = 5;
	localparam int OPC_LSB = 8;
	// Opcode nibbles of the two skip forms.
	localparam logic [OPC_W-1:0] OPC_SKIP_IF_BIT_CLEAR = 4'h6;
	localparam logic [OPC_W-1:0] OPC_SKIP_IF_BIT_SET = 4'h7;
	// The no-operation word that replaces a squashed instruction.
	localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
	localparam logic [1:0] CYCLES_PLAIN = 2'h1;
	localparam logic [1:0] CYCLES_SKIPPED = 2'h2;

	typedef enum logic [1:0] {
		BTSE_OP_OTHER,
		BTSE_OP_SKIP_CLEAR,
		BTSE_OP_SKIP_SET
	} btse_op_t;

	function automatic btse_op_t btse_decode(input logic [INSTR_W-1:0] word);
		btse_op_t op;
		op = BTSE_OP_OTHER;
		case (word[OPC_LSB +: OPC_W])
			OPC_SKIP_IF_BIT_CLEAR: begin
				op = BTSE_OP_SKIP_CLEAR;
			end
			OPC_SKIP_IF_BIT_SET: begin
				op = BTSE_OP_SKIP_SET;
			end
			default: begin
				op = BTSE_OP_OTHER;
			end
		endcase
		return op;
	endfunction
endpackage

// ============================================================
// Bit test leaf
// ============================================================
module btse_bit_test import btse_pkg::*; (
	// Operand
	input wire logic [DATA_W-1:0] file_data_i,
	input wire logic [BSEL_W-1:0] bit_sel_i,
	// Test polarity: high tests for a set bit, low for a clear bit
	input wire logic want_set_i,
	// Result
	output logic bit_o,
	output logic match_o
);
	always_comb begin
		bit_o = file_data_i[bit_sel_i];
		match_o = (bit_o == want_set_i);
	end
endmodule

// *** btse_core.sv ***
`timescale 1ns/1ps
// Purpose: Execute-stage slice for the skip_if_bit_clear and skip_if_bit_set instructions.
// Assumes: Fetch delivers one word per cycle with a valid strobe; file read data returns in the same cycle
// as the registered read address.
// Notes: A taken skip replaces the next valid fetched word with a no-operation in the execute register.
//
// Overview of operation
// - Words 0110 bbbf ffff skip the next instruction when the chosen bit is zero.
// - Clear-test takes one cycle unskipped; a skip executes a no-operation, two cycles total.
// - Set-test skip discards the prefetched instruction and executes a no-operation instead.
// - Five-bit field addresses registers 0-31; three-bit field picks bit 0-7.
// - Words 0111 bbbf ffff skip the next instruction when the chosen bit is one.

module btse_core import btse_pkg::*; (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// Fetch side
	input wire logic [INSTR_W-1:0] fetch_word_i,
	input wire logic fetch_valid_i,
	// File register read port
	input wire logic [DATA_W-1:0] file_rdata_i,
	output logic [FADDR_W-1:0] file_addr_o,
	output logic file_rd_o,
	// Execute stage view
	output logic [INSTR_W-1:0] exec_word_o,
	output logic exec_valid_o,
	output logic exec_squashed_o,
	output logic [1:0] exec_cycles_o,
	// Write enables the slice owns; always idle
	output logic file_we_o,
	output logic status_we_o
);

	// ============================================================
	// State
	// ============================================================
	typedef struct packed {
		logic [INSTR_W-1:0] exec_word;
		logic exec_valid;
		logic exec_squashed;
		logic skip_pending;
		logic [1:0] exec_cycles;
		logic file_we;
		logic status_we;
	} btse_state_t;

	btse_state_t state_r;
	btse_state_t state_nxt;

	btse_op_t exec_op;
	logic test_match;
	logic skip_now;

	// The register address and bit select come straight from the word held in execute.
	btse_bit_test u_bit_test (
		.file_data_i(file_rdata_i),
		.bit_sel_i(state_r.exec_word[BSEL_LSB +: BSEL_W]),
		.want_set_i(exec_op == BTSE_OP_SKIP_SET),
		.bit_o(),
		.match_o(test_match)
	);

	// Decode sits in its own process so the bit test result does not loop back into it.
	always_comb begin
		exec_op = btse_decode(state_r.exec_word);
	end

	// ============================================================
	// Next state
	// ============================================================
	always_comb begin
		state_nxt = state_r;
		// A squashed slot holds the no-operation word, so it can never skip again.
		skip_now = state_r.exec_valid && !state_r.exec_squashed && (exec_op != BTSE_OP_OTHER) && test_match;
		// A skip waits across fetch bubbles until a real word arrives to be discarded.
		state_nxt.skip_pending = skip_now || (state_r.skip_pending && !fetch_valid_i);
		state_nxt.exec_valid = fetch_valid_i;
		if (fetch_valid_i && (skip_now || state_r.skip_pending)) begin
			state_nxt.exec_word = NOP_WORD;
			state_nxt.exec_squashed = 1'b1;
			state_nxt.skip_pending = 1'b0;
		end else if (fetch_valid_i) begin
			state_nxt.exec_word = fetch_word_i;
			state_nxt.exec_squashed = 1'b0;
		end else begin
			state_nxt.exec_word = NOP_WORD;
			state_nxt.exec_squashed = 1'b0;
		end
		// Cycle count of the skip instruction as it retires: two when it skipped.
		if (skip_now) begin
			state_nxt.exec_cycles = CYCLES_SKIPPED;
		end else begin
			state_nxt.exec_cycles = CYCLES_PLAIN;
		end
		// Skip forms only read; the write enables stay low for them.
		state_nxt.file_we = 1'b0;
		state_nxt.status_we = 1'b0;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= '{exec_word: NOP_WORD, exec_valid: 1'b0, exec_squashed: 1'b0, skip_pending: 1'b0,
				exec_cycles: CYCLES_PLAIN, file_we: 1'b0, status_we: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	// ============================================================
	// Outputs
	// ============================================================
	always_comb begin
		file_addr_o = state_r.exec_word[FADDR_LSB +: FADDR_W];
		file_rd_o = state_r.exec_valid;
		exec_word_o = state_r.exec_word;
		exec_valid_o = state_r.exec_valid;
		exec_squashed_o = state_r.exec_squashed;
		exec_cycles_o = state_r.exec_cycles;
		file_we_o = state_r.file_we;
		status_we_o = state_r.status_we;
	end

endmodule

// *** btse_core_asserts.sv ***
// Purpose: Port assertions for btse_core.
// Assumes: One clock; reset is asynchronous and active high.
// Notes: The keep check relies on a skip form never sitting in a squashed slot.
`timescale 1ns/1ps
// ============================================================
// Port checker
// ============================================================
module btse_core_asserts import btse_pkg::*; (
	input wire logic sys_clk_i, sys_rst_i, fetch_valid_i, file_rd_o, exec_valid_o, exec_squashed_o,
	input wire logic file_we_o, status_we_o,
	input wire logic [11:0] fetch_word_i, exec_word_o,
	input wire logic [7:0] file_rdata_i,
	input wire logic [4:0] file_addr_o,
	input wire logic [1:0] exec_cycles_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire hit = file_rdata_i[exec_word_o[7:5]];
	wire go = exec_valid_o && fetch_valid_i;
	sequence s_sq; exec_squashed_o && exec_word_o == 12'h000 && exec_cycles_o == 2'h2; endsequence
	property p_clr; go && exec_word_o[11:8] == 4'h6 && !hit |=> s_sq; endproperty
	a_clr: assert property (p_clr) else $error("clear skip lost");
	property p_set; go && exec_word_o[11:8] == 4'h7 && hit |=> s_sq; endproperty
	a_set: assert property (p_set) else $error("set skip lost");
	property p_keep; go && exec_word_o[11:9] == 3'h3 && (exec_word_o[8] ^ hit) |=>
		!exec_squashed_o && exec_word_o == $past(fetch_word_i) && exec_cycles_o == 2'h1; endproperty
	a_keep: assert property (p_keep) else $error("false skip");
	property p_addr; exec_valid_o && !exec_squashed_o |-> file_rd_o && file_addr_o == exec_word_o[4:0]; endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_once; exec_squashed_o |=> !exec_squashed_o; endproperty
	a_once: assert property (p_once) else $error("double squash");
	property p_nowr; !(file_we_o || status_we_o); endproperty
	a_nowr: assert property (p_nowr) else $error("write seen");
endmodule
bind btse_core btse_core_asserts chk_u (.*);

// *** btse_tb.sv ***
// Purpose: Self-checking bench for btse_core.
// Assumes: Inputs change 5 ns after each rising edge.
// Notes: Each word driven by run is followed by a filler word and a bubble, so no skip leaks into the next.
`timescale 1ns/1ps
// ============================================================
// Bench
// ============================================================
module tb;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, fetch_valid_i = 1'b0;
	logic file_rd_o, exec_valid_o, exec_squashed_o, file_we_o, status_we_o;
	logic [11:0] fetch_word_i = 12'h000, exec_word_o;
	logic [7:0] file_rdata_i = 8'h00;
	logic [4:0] file_addr_o;
	logic [1:0] exec_cycles_o;
	int err_count = 0, comparisons = 0;
	btse_core dut_u (.*);
	initial forever #25 sys_clk_i = ~sys_clk_i;
	task chk(input string n, input logic [11:0] e, input logic [11:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task tick;
		@(posedge sys_clk_i);
		#5;
	endtask
	task run(input logic [11:0] w, input logic [7:0] d, input logic sq);
		fetch_word_i = w;
		fetch_valid_i = 1'b1;
		tick();
		chk("word", w, exec_word_o);
		chk("addr", {7'h0, w[4:0]}, {7'h0, file_addr_o});
		chk("read", 12'h003, {10'h0, exec_valid_o, file_rd_o});
		file_rdata_i = d;
		fetch_word_i = 12'ha5c;
		tick();
		chk("squash", {11'h0, sq}, {11'h0, exec_squashed_o});
		chk("next", sq ? 12'h000 : 12'ha5c, exec_word_o);
		chk("cycles", sq ? 12'h002 : 12'h001, {10'h0, exec_cycles_o});
		chk("writes", 12'h000, {10'h0, file_we_o, status_we_o});
		fetch_valid_i = 1'b0;
		tick();
		chk("bubble", 12'h000, {10'h0, exec_valid_o, file_rd_o});
	endtask
	task sc_clear;
		run(12'h6a3, 8'hdf, 1'b1);
		run(12'h6a3, 8'h20, 1'b0);
		run(12'h6ff, 8'h7f, 1'b1);
		run(12'h600, 8'h01, 1'b0);
		$display("clear test end");
	endtask
	task sc_set;
		run(12'h7e0, 8'h80, 1'b1);
		run(12'h71f, 8'hfe, 1'b0);
		run(12'h5a3, 8'h00, 1'b0);
		$display("set test end");
	endtask
	task sc_pending;
		fetch_word_i = 12'h6a3;
		fetch_valid_i = 1'b1;
		tick();
		file_rdata_i = 8'h00;
		fetch_valid_i = 1'b0;
		tick();
		chk("gap", 12'h002, {9'h0, exec_valid_o, exec_cycles_o});
		fetch_word_i = 12'ha5c;
		fetch_valid_i = 1'b1;
		tick();
		chk("late squash word", 12'h000, exec_word_o);
		chk("late squash flag", 12'h001, {11'h0, exec_squashed_o});
		fetch_word_i = 12'h6a3;
		tick();
		chk("second skip word", 12'h6a3, exec_word_o);
		fetch_valid_i = 1'b0;
		tick();
		sys_rst_i = 1'b1;
		tick();
		chk("reset word", 12'h000, exec_word_o);
		chk("reset state", 12'h001, {7'h0, exec_valid_o, file_rd_o, exec_squashed_o, exec_cycles_o});
		chk("reset addr", 12'h000, {7'h0, file_addr_o});
		sys_rst_i = 1'b0;
		fetch_word_i = 12'ha5c;
		fetch_valid_i = 1'b1;
		tick();
		chk("after reset word", 12'ha5c, exec_word_o);
		chk("after reset flag", 12'h000, {11'h0, exec_squashed_o});
		fetch_valid_i = 1'b0;
		tick();
		$display("pending test end");
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (4) tick();
		sys_rst_i = 1'b0;
		sc_clear();
		sc_set();
		sc_pending();
		wrap_up();
	end
endmodule
